// *** rtl/bbs_pkg.sv ***
/*
  Constants, register map and types of the baseband data and control
  source. Assumes a single 25 MHz core clock and an APB register bus.
*/
package bbs_pkg;

  localparam int ADDR_W = 8;
  localparam int CNT_W  = 16;
  localparam int LFSR_W = 23;
  localparam int SYM_W  = 4;

  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PAT_LO    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PAT_HI    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PAT_LEN   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LIST_LEN  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LIST_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LIST_DATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_BIT_DIV   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_GATE_LO   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ATT_HI    = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_ATT_AMT   = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_RAMP_TIME = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_RISE_DLY  = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_FALL_DLY  = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h40;

  localparam int CTRL_W       = 14;
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_SRC     = 1;
  localparam int CTRL_PRBS    = 4;
  localparam int CTRL_BPS     = 7;
  localparam int CTRL_RAMP_EN = 9;
  localparam int CTRL_ATT_EN  = 10;
  localparam int CTRL_UNMOD   = 11;
  localparam int CTRL_CLKO_EN = 12;
  localparam int CTRL_CTLO_EN = 13;
  localparam int CTRL_RESTART = 14;

  localparam logic [CTRL_W-1:0] CTRL_RST    = 14'h0000;
  localparam logic [CNT_W-1:0]  BIT_DIV_RST = 16'h0003;
  localparam logic [CNT_W-1:0]  DUR_RST     = 16'h000f;
  localparam logic [5:0]        PAT_LEN_RST = 6'h3f;
  localparam logic [LFSR_W-1:0] SEED_INV    = 23'h000001;

  typedef enum logic [2:0] {
    SRC_ZERO = 3'b000,
    SRC_ONE  = 3'b001,
    SRC_PAT  = 3'b010,
    SRC_LIST = 3'b011,
    SRC_PRBS = 3'b100
  } bbs_src_t;

  typedef enum logic [2:0] {
    PRBS_9  = 3'b000,
    PRBS_11 = 3'b001,
    PRBS_15 = 3'b010,
    PRBS_16 = 3'b011,
    PRBS_20 = 3'b100,
    PRBS_21 = 3'b101,
    PRBS_23 = 3'b110
  } bbs_prbs_t;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_WAIT = 2'b01,
    RAMP_RUN  = 2'b10
  } bbs_ramp_t;

endpackage

// *** rtl/bbs_top.sv ***
/*
  Baseband data and control source: bit sources, symbol packer, symbol
  FIFO, burst gate, attenuation and ramp start logic, APB slave.
  Assumes the modulator takes symbols on a valid/ready handshake and
  that all inputs are synchronous to core_clk.
*/
// The APB register port and the address map were chosen for this implementation.
////////////////////////////////////////////////////////////////////////
module bbs_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
  begin : g_bad_size
    $error("bbs_fifo: DEPTH must be a power of two >= 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn || clr)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      if (push && !pop)
        count_reg <= count_reg + (AW+1)'(1);
      else if (pop && !push)
        count_reg <= count_reg - (AW+1)'(1);
    end
  end
endmodule // bbs_fifo

////////////////////////////////////////////////////////////////////////
module bbs_top
  import bbs_pkg::*;
#(
  parameter int LIST_WORDS = 64,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sym_ready,
  output logic [SYM_W-1:0]       sym_data,
  output logic                   sym_valid,
  output logic                   sym_clk_out,
  output logic                   burst_gate,
  output logic                   lev_att,
  output logic [7:0]             att_amount,
  output logic                   unmod_select_ctl,
  output logic                   mod_enable,
  output logic                   ramp_active,
  output logic                   ramp_rising,
  output logic                   tm_gate_out,
  output logic                   tm_att_out
);
  localparam int LAW = $clog2(LIST_WORDS);

  if (LIST_WORDS < 2 || (1 << LAW) != LIST_WORDS)
  begin : g_bad_list
    $error("bbs_top: LIST_WORDS must be a power of two >= 2");
  end

  logic [CTRL_W-1:0]  ctrl_reg;
  logic               restart_reg;
  logic [63:0]        pat_reg;
  logic [5:0]         pat_len_reg;
  logic [LAW+4:0]     list_len_reg;
  logic [LAW-1:0]     list_wptr_reg;
  logic [31:0]        list_mem [LIST_WORDS];
  logic [CNT_W-1:0]   bit_div_reg;
  logic [CNT_W-1:0]   dur_reg [4];
  logic [7:0]         att_amt_reg;
  logic [CNT_W-1:0]   ramp_time_reg;
  logic [CNT_W-1:0]   rise_dly_reg;
  logic [CNT_W-1:0]   fall_dly_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  bbs_src_t           src;
  bbs_prbs_t          ptype;
  logic               apb_wr;
  logic               apb_rd;
  logic [31:0]        status_word;

  assign src    = bbs_src_t'(ctrl_reg[CTRL_SRC +: 3]);
  assign ptype  = bbs_prbs_t'(ctrl_reg[CTRL_PRBS +: 3]);
  // One wait state, so prdata and pready both come from flip-flops
  assign apb_rd = psel & penable & ~pready_reg;
  assign apb_wr = psel & penable & pready_reg & pwrite;

  ////////////////////////////////////////////////////////////////////////
  // Generator helpers
  function automatic int lfsr_len(bbs_prbs_t t);
    case (t)
      PRBS_11: return 11;
      PRBS_15: return 15;
      PRBS_16: return 16;
      PRBS_20: return 20;
      PRBS_21: return 21;
      PRBS_23: return 23;
      default: return 9;
    endcase
  endfunction

  function automatic logic [LFSR_W-1:0] lfsr_seed(bbs_prbs_t t);
    logic [LFSR_W-1:0] ones;
    ones = LFSR_W'((24'h1 << lfsr_len(t)) - 24'h1);
    // Inverted feedback locks up in all ones, so those start from one
    if (t == PRBS_15 || t == PRBS_23)
      return SEED_INV;
    return ones;
  endfunction

  function automatic logic [LFSR_W-1:0] lfsr_step(logic [LFSR_W-1:0] s,
                                                 bbs_prbs_t t);
    logic              fb;
    logic [LFSR_W-1:0] n;
    case (t)
      PRBS_11: fb = s[0] ^ s[2];
      PRBS_15: fb = ~(s[0] ^ s[1]);
      PRBS_16: fb = s[0] ^ s[2] ^ s[3] ^ s[5];
      PRBS_20: fb = s[0] ^ s[3];
      PRBS_21: fb = s[0] ^ s[2];
      PRBS_23: fb = ~(s[0] ^ s[5]);
      default: fb = s[0] ^ s[4];
    endcase
    n = (s >> 1) & LFSR_W'((24'h1 << lfsr_len(t)) - 24'h1);
    n[lfsr_len(t)-1] = fb;
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= apb_rd;
      pslverr_reg <= 1'b0;
      if (apb_rd)
      begin
        prdata_reg <= 32'h0000_0000;
        if (paddr == OFS_CTRL)
          prdata_reg <= 32'(ctrl_reg);
        else if (paddr == OFS_PAT_LO)
          prdata_reg <= pat_reg[31:0];
        else if (paddr == OFS_PAT_HI)
          prdata_reg <= pat_reg[63:32];
        else if (paddr == OFS_PAT_LEN)
          prdata_reg <= 32'(pat_len_reg);
        else if (paddr == OFS_LIST_LEN)
          prdata_reg <= 32'(list_len_reg);
        else if (paddr == OFS_LIST_ADDR)
          prdata_reg <= 32'(list_wptr_reg);
        else if (paddr == OFS_LIST_DATA)
          prdata_reg <= list_mem[list_wptr_reg];
        else if (paddr == OFS_BIT_DIV)
          prdata_reg <= 32'(bit_div_reg);
        else if (paddr >= OFS_GATE_LO && paddr <= OFS_ATT_HI)
          prdata_reg <= 32'(dur_reg[paddr[3:2]]);
        else if (paddr == OFS_ATT_AMT)
          prdata_reg <= 32'(att_amt_reg);
        else if (paddr == OFS_RAMP_TIME)
          prdata_reg <= 32'(ramp_time_reg);
        else if (paddr == OFS_RISE_DLY)
          prdata_reg <= 32'(rise_dly_reg);
        else if (paddr == OFS_FALL_DLY)
          prdata_reg <= 32'(fall_dly_reg);
        else if (paddr == OFS_STATUS)
          prdata_reg <= status_word;
        else if (!pwrite)
          pslverr_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (apb_wr && paddr == OFS_LIST_DATA)
      list_mem[list_wptr_reg] <= pwdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ctrl_reg      <= CTRL_RST;
      restart_reg   <= 1'b0;
      pat_reg       <= 64'h0;
      pat_len_reg   <= PAT_LEN_RST;
      list_len_reg  <= '0;
      list_wptr_reg <= '0;
      bit_div_reg   <= BIT_DIV_RST;
      dur_reg       <= '{DUR_RST, DUR_RST, DUR_RST, DUR_RST};
      att_amt_reg   <= 8'h00;
      ramp_time_reg <= DUR_RST;
      rise_dly_reg  <= 16'h0000;
      fall_dly_reg  <= 16'h0000;
    end
    else
    begin
      restart_reg <= apb_wr && paddr == OFS_CTRL && pwdata[CTRL_RESTART];
      if (apb_wr)
      begin
        if (paddr == OFS_CTRL)
          ctrl_reg <= pwdata[CTRL_W-1:0];
        else if (paddr == OFS_PAT_LO)
          pat_reg[31:0] <= pwdata;
        else if (paddr == OFS_PAT_HI)
          pat_reg[63:32] <= pwdata;
        else if (paddr == OFS_PAT_LEN)
          pat_len_reg <= pwdata[5:0];
        else if (paddr == OFS_LIST_LEN)
          list_len_reg <= pwdata[LAW+4:0];
        else if (paddr == OFS_LIST_ADDR)
          list_wptr_reg <= pwdata[LAW-1:0];
        else if (paddr == OFS_LIST_DATA)
          list_wptr_reg <= list_wptr_reg + LAW'(1);
        else if (paddr == OFS_BIT_DIV)
          bit_div_reg <= pwdata[CNT_W-1:0];
        else if (paddr >= OFS_GATE_LO && paddr <= OFS_ATT_HI)
          dur_reg[paddr[3:2]] <= pwdata[CNT_W-1:0];
        else if (paddr == OFS_ATT_AMT)
          att_amt_reg <= pwdata[7:0];
        else if (paddr == OFS_RAMP_TIME)
          ramp_time_reg <= pwdata[CNT_W-1:0];
        else if (paddr == OFS_RISE_DLY)
          rise_dly_reg <= pwdata[CNT_W-1:0];
        else if (paddr == OFS_FALL_DLY)
          fall_dly_reg <= pwdata[CNT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit sources and symbol packer
  logic [CNT_W-1:0]   div_cnt_reg;
  logic [LFSR_W-1:0]  lfsr_reg;
  logic [5:0]         pat_idx_reg;
  logic [LAW+4:0]     list_idx_reg;
  logic [SYM_W-1:0]   acc_reg;
  logic [1:0]         acc_cnt_reg;
  logic               acc_full_reg;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [SYM_W-1:0]   fifo_out_data;
  logic               bit_step;
  logic               cur_bit;
  logic               take;
  logic [LAW-1:0]     list_word;

  // A full packer holds the bit clock, so a stalled modulator fills the
  // FIFO and then freezes the sources without losing bits
  assign bit_step  = ctrl_reg[CTRL_RUN] & ~acc_full_reg
                     & (div_cnt_reg >= bit_div_reg);
  assign list_word = list_idx_reg[LAW+4:5];

  always_comb
  begin
    case (src)
      SRC_ONE:  cur_bit = 1'b1;
      SRC_PAT:  cur_bit = pat_reg[pat_idx_reg];
      SRC_LIST: cur_bit = list_mem[list_word][list_idx_reg[4:0]];
      SRC_PRBS: cur_bit = lfsr_reg[0];
      default:  cur_bit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn || restart_reg || bit_step)
      div_cnt_reg <= '0;
    else if (ctrl_reg[CTRL_RUN] && div_cnt_reg < bit_div_reg)
      div_cnt_reg <= div_cnt_reg + CNT_W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      lfsr_reg     <= lfsr_seed(PRBS_9);
      pat_idx_reg  <= '0;
      list_idx_reg <= '0;
    end
    else if (restart_reg)
    begin
      lfsr_reg     <= lfsr_seed(ptype);
      pat_idx_reg  <= '0;
      list_idx_reg <= '0;
    end
    else if (bit_step)
    begin
      if (src == SRC_PRBS)
        lfsr_reg <= lfsr_step(lfsr_reg, ptype);
      if (src == SRC_PAT)
        pat_idx_reg <= (pat_idx_reg >= pat_len_reg) ? 6'h00
                       : pat_idx_reg + 6'h01;
      if (src == SRC_LIST)
        list_idx_reg <= (list_idx_reg + 1'b1 >= list_len_reg) ? '0
                        : list_idx_reg + (LAW+5)'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn || restart_reg)
    begin
      acc_reg      <= '0;
      acc_cnt_reg  <= 2'b00;
      acc_full_reg <= 1'b0;
    end
    else
    begin
      if (acc_full_reg && fifo_in_ready)
        acc_full_reg <= 1'b0;
      if (bit_step)
      begin
        // A fresh symbol starts from zero so only its own bits show
        acc_reg <= (acc_cnt_reg == 2'b00) ? {{(SYM_W-1){1'b0}}, cur_bit}
                   : {acc_reg[SYM_W-2:0], cur_bit};
        if (acc_cnt_reg == ctrl_reg[CTRL_BPS +: 2])
        begin
          acc_cnt_reg  <= 2'b00;
          acc_full_reg <= 1'b1;
        end
        else
          acc_cnt_reg <= acc_cnt_reg + 2'b01;
      end
    end
  end

  bbs_fifo #(
    .W     (SYM_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .clr       (restart_reg),
    .in_valid  (acc_full_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (acc_reg),
    .out_valid (fifo_out_valid),
    .out_ready (take),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Burst gate and attenuation rectangles, index 0 gate, 1 attenuation
  logic [1:0]       rect_reg;
  logic [CNT_W-1:0] rect_cnt_reg [2];

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_rect
      logic [CNT_W-1:0] dur;
      assign dur = dur_reg[2*i + int'(rect_reg[i])];
      always_ff @(posedge core_clk)
      begin
        if (!rstn || restart_reg || !ctrl_reg[CTRL_RUN])
        begin
          rect_reg[i]     <= 1'b0;
          rect_cnt_reg[i] <= '0;
        end
        else if ({1'b0, rect_cnt_reg[i]} + 17'h1 >= {1'b0, dur})
        begin
          rect_reg[i]     <= ~rect_reg[i];
          rect_cnt_reg[i] <= '0;
        end
        else
          rect_cnt_reg[i] <= rect_cnt_reg[i] + CNT_W'(1);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Power ramp start: delay then ramp time, restarted by any gate edge
  bbs_ramp_t        ramp_st_reg;
  logic [CNT_W-1:0] ramp_cnt_reg;
  logic             gate_q_reg;
  logic             ramp_rise_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ramp_st_reg   <= RAMP_IDLE;
      ramp_cnt_reg  <= '0;
      gate_q_reg    <= 1'b0;
      ramp_rise_reg <= 1'b0;
    end
    else
    begin
      gate_q_reg <= rect_reg[0];
      if (ctrl_reg[CTRL_RAMP_EN] && gate_q_reg != rect_reg[0])
      begin
        ramp_st_reg   <= RAMP_WAIT;
        ramp_rise_reg <= rect_reg[0];
        ramp_cnt_reg  <= rect_reg[0] ? rise_dly_reg : fall_dly_reg;
      end
      else
      begin
        case (ramp_st_reg)
          RAMP_WAIT:
            if (ramp_cnt_reg == '0)
            begin
              ramp_st_reg  <= RAMP_RUN;
              ramp_cnt_reg <= ramp_time_reg;
            end
            else
              ramp_cnt_reg <= ramp_cnt_reg - CNT_W'(1);
          RAMP_RUN:
            if (ramp_cnt_reg <= CNT_W'(1))
              ramp_st_reg <= RAMP_IDLE;
            else
              ramp_cnt_reg <= ramp_cnt_reg - CNT_W'(1);
          default:
            ramp_st_reg <= RAMP_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage, all on the rising edge
  logic [SYM_W-1:0] sym_data_reg;
  logic             sym_valid_reg;
  logic             sym_clk_reg;
  logic [6:0]       ctl_reg;
  logic [7:0]       att_out_reg;

  // Symbols leave only while the gate is high
  assign take = fifo_out_valid & rect_reg[0]
                & (~sym_valid_reg | sym_ready);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sym_data_reg  <= '0;
      sym_valid_reg <= 1'b0;
      sym_clk_reg   <= 1'b0;
      ctl_reg       <= 7'h00;
      att_out_reg   <= 8'h00;
    end
    else
    begin
      if (take)
        sym_data_reg <= fifo_out_data;
      if (take)
        sym_valid_reg <= 1'b1;
      else if (sym_ready)
        sym_valid_reg <= 1'b0;
      sym_clk_reg <= take & ctrl_reg[CTRL_CLKO_EN];
      ctl_reg[0]  <= rect_reg[0];
      ctl_reg[1]  <= rect_reg[1] & ctrl_reg[CTRL_ATT_EN];
      ctl_reg[2]  <= ctrl_reg[CTRL_UNMOD];
      ctl_reg[3]  <= ctrl_reg[CTRL_RUN] & ~ctrl_reg[CTRL_UNMOD];
      ctl_reg[4]  <= ramp_st_reg == RAMP_RUN;
      ctl_reg[5]  <= rect_reg[0] & ctrl_reg[CTRL_CTLO_EN];
      ctl_reg[6]  <= rect_reg[1] & ctrl_reg[CTRL_CTLO_EN];
      att_out_reg <= (rect_reg[1] && ctrl_reg[CTRL_ATT_EN]) ? att_amt_reg
                     : 8'h00;
    end
  end

  assign status_word = {1'b0, lfsr_reg, 2'b00, ramp_rise_reg,
                        ramp_st_reg == RAMP_RUN, acc_full_reg,
                        ~fifo_in_ready, rect_reg[1], rect_reg[0]};

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign sym_data         = sym_data_reg;
  assign sym_valid        = sym_valid_reg;
  assign sym_clk_out      = sym_clk_reg;
  assign burst_gate       = ctl_reg[0];
  assign lev_att          = ctl_reg[1];
  assign unmod_select_ctl = ctl_reg[2];
  assign mod_enable       = ctl_reg[3];
  assign ramp_active      = ctl_reg[4];
  assign ramp_rising      = ramp_rise_reg;
  assign tm_gate_out      = ctl_reg[5];
  assign tm_att_out       = ctl_reg[6];
  assign att_amount       = att_out_reg;
endmodule // bbs_top

// *** bench/bbs_top_assertions.sv ***
/* Port checker for bbs_top, bound at the foot of this file.
   Assumes one clock core_clk and synchronous reset rstn. */
module bbs_chk
  import bbs_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rstn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             sym_ready,
  input wire logic             sym_valid,
  input wire logic [SYM_W-1:0] sym_data,
  input wire logic             sym_clk_out,
  input wire logic             lev_att,
  input wire logic [7:0]       att_amount,
  input wire logic             unmod_select_ctl,
  input wire logic             mod_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_pready_wait: assert property (
    psel && penable && !pready |=> pready) else $error("pready late");
  a_pready_pulse: assert property (
    pready |=> !pready) else $error("pready too long");
  a_err_read: assert property (
    pslverr |-> pready && !pwrite) else $error("bad pslverr");
  a_sym_hold: assert property (
    sym_valid && !sym_ready
    |=> sym_valid && $stable(sym_data)) else $error("symbol dropped");
  a_symclk_valid: assert property (
    sym_clk_out |-> sym_valid) else $error("stray symbol clock");
  a_unmod_stop: assert property (
    unmod_select_ctl |-> !mod_enable) else $error("modulation on");
  a_att_idle: assert property (
    !lev_att |-> att_amount == 8'h00) else $error("amount leak");
  // Own disable: this one must see the reset itself
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn |=> !sym_valid && !pready && !lev_att)
    else $error("output live in reset");

  c_sym: cover property (sym_valid && sym_ready);
  c_err: cover property (pslverr);
  c_att: cover property (lev_att);
endmodule // bbs_chk

bind bbs_top bbs_chk i_bbs_chk (.core_clk, .rstn, .psel, .penable,
  .pwrite, .pready, .pslverr, .sym_ready, .sym_valid, .sym_data,
  .sym_clk_out, .lev_att, .att_amount, .unmod_select_ctl, .mod_enable);

// *** bench/bbs_mod_model.sv ***
/* Modulator stand-in: takes symbols on valid/ready, may stall or
   accept every other cycle. Assumes core_clk shared with bbs_top. */
module bbs_mod_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       sym_valid,
  input  wire logic [3:0] sym_data,
  input  wire logic       stall,
  input  wire logic       slow,
  output logic            sym_ready
);
  logic       tog_reg;
  logic [3:0] rx_q[$];

  // Ready never looks at sym_valid, so no loop through the design
  assign sym_ready = rstn && !stall && (!slow || tog_reg);

  always_ff @(posedge core_clk)
  begin
    tog_reg <= rstn ? !tog_reg : 1'b0;
    if (sym_valid && sym_ready)
      rx_q.push_back(sym_data);
  end
endmodule // bbs_mod_model

// *** bench/test_bbs_top.sv ***
/* Bench for bbs_top: APB tasks set registers, the modulator model
   collects symbols. Assumes one 25 MHz clock. */
module test_bbs_top;
  import bbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        stall = 0, slow = 0, pready, pslverr, er, sym_ready;
  logic        sym_valid, sym_clk_out, burst_gate, lev_att, mod_enable;
  logic        unmod_select_ctl, ramp_active, ramp_rising;
  logic        tm_gate_out, tm_att_out;
  logic [7:0]  paddr = 8'h00, att_amount;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  sym_data;
  int          failures = 0, checks_done = 0, b;

  always #20 core_clk = ~core_clk;

  bbs_top i_bbs_top (.core_clk, .rstn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .sym_ready, .sym_data, .sym_valid,
    .sym_clk_out, .burst_gate, .lev_att, .att_amount, .unmod_select_ctl,
    .mod_enable, .ramp_active, .ramp_rising, .tm_gate_out, .tm_att_out);
  bbs_mod_model i_bbs_mod_model (.core_clk, .rstn, .sym_valid, .sym_data,
    .stall, .slow, .sym_ready);

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; holds the request until pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic waitq(input int want);
    int n = 0;
    while (i_bbs_mod_model.rx_q.size() < want && n++ < 10000)
      @(posedge core_clk);
    if (n > 10000) failures++;
  endtask

  task automatic waitsig(ref logic sg);
    int n = 0;
    while (sg !== 1'b1 && n++ < 300)
      @(posedge core_clk);
  endtask

  function automatic logic s(input int i);
    return i_bbs_mod_model.rx_q[i][0];
  endfunction

  // Output bit n+len follows from bits n and n+tap of the stream, and also n+2 and n+3 for PRBS_16
  task automatic prbs(input int k, len, tap, inv);
    int o = 0;
    xfer(1'b1, OFS_CTRL, 32'h4009 | (k << 4));
    // Let the restart clear the FIFO and the old output symbol leave first
    repeat (2) @(posedge core_clk);
    b = i_bbs_mod_model.rx_q.size();
    waitq(b + 64 + ((len < 12) ? (1 << len) : 0));
    for (int i = b; i < b + 40; i++)
    begin
      o += s(i);
      chk("prbs bit", s(i) ^ s(i + tap) ^ inv[0] ^
        ((k == 3) ? s(i + 2) ^ s(i + 3) : 1'b0), s(i + len));
    end
    chk("prbs live", 1, o != 0);
    if (len < 12)
      chk("prbs period", s(b + 3), s(b + 2 + (1 << len)));
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    xfer(1'b0, OFS_CTRL, 0);
    chk("ctrl", 0, rd);
    xfer(1'b0, OFS_PAT_LEN, 0);
    chk("pat len", 32'h3f, rd);
    xfer(1'b0, OFS_GATE_LO, 0);
    chk("gate lo", 32'hf, rd);
    xfer(1'b0, 8'hfc, 0);
    chk("unmapped", 32'h1, {rd, er});
    xfer(1'b1, OFS_ATT_AMT, 32'h5a);
    xfer(1'b0, OFS_ATT_AMT, 0);
    chk("att amt", 32'h5a, rd);
    $display("test registers done");
    xfer(1'b1, OFS_BIT_DIV, 0);
    xfer(1'b1, OFS_GATE_LO, 0);
    xfer(1'b1, OFS_GATE_LO + 8'h04, 32'hffff);
    prbs(0, 9, 4, 0);
    prbs(1, 11, 2, 0);
    prbs(2, 15, 1, 1);
    prbs(3, 16, 5, 0);
    prbs(4, 20, 3, 0);
    prbs(5, 21, 2, 0);
    prbs(6, 23, 5, 1);
    $display("test prbs done");
    slow <= 1'b1;
    for (int n = 0; n < 5; n++)
    begin
      xfer(1'b1, OFS_CTRL, (n < 4) ? 32'h4003 | (n << 7) : 32'h4181);
      waitq(i_bbs_mod_model.rx_q.size() + 3);
      chk("symbol", (n < 4) ? (32'h1 << (n + 1)) - 1 : 0,
        {28'h0, i_bbs_mod_model.rx_q[$]});
    end
    stall <= 1'b1;
    xfer(1'b1, OFS_CTRL, 32'h4003);
    repeat (40) @(posedge core_clk);
    xfer(1'b0, OFS_STATUS, 0);
    chk("fifo full", 32'h3, {rd[2], sym_valid});
    stall <= 1'b0;
    waitq(i_bbs_mod_model.rx_q.size() + 9);
    chk("drained", 32'h1, {28'h0, i_bbs_mod_model.rx_q[$]});
    $display("test symbols done");
    xfer(1'b1, OFS_ATT_HI - 8'h04, 2);
    xfer(1'b1, OFS_ATT_HI, 3);
    xfer(1'b1, OFS_GATE_LO, 3);
    xfer(1'b1, OFS_GATE_LO + 8'h04, 3);
    xfer(1'b1, OFS_RAMP_TIME, 4);
    xfer(1'b1, OFS_CTRL, 32'h7e03);
    waitsig(lev_att);
    chk("att", 32'h15a, {tm_att_out, att_amount});
    chk("unmod", 2, {unmod_select_ctl, mod_enable});
    waitsig(sym_clk_out);
    chk("sym clk", 1, sym_clk_out);
    waitsig(ramp_active);
    chk("ramp", 1, ramp_active);
    waitsig(tm_gate_out);
    chk("gate out", 7, {tm_gate_out, burst_gate, ramp_rising});
    $display("test controls done");
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
endmodule // test_bbs_top
